// ### core/rcs_consts.svh
// Purpose: constants for the reset cause and forced reset block
// Assumes: included by its bare name from the package and the design file
// Notes:   bit positions refer to the 8-bit reset cause status register
`ifndef RCS_CONSTS_SVH
`define RCS_CONSTS_SVH

// flag positions in the reset cause status register
`define RCS_BIT_POWERUP      7
`define RCS_BIT_EXT_LINE     6
`define RCS_BIT_WATCHDOG     5
`define RCS_BIT_BAD_OPCODE   4
`define RCS_BIT_BAD_ADDRESS  3
`define RCS_BIT_OSC_MISSING  2
`define RCS_BIT_UNDERVOLTAGE 1

// status after a power-on reset: power-up and undervoltage flags
`define RCS_POR_STATUS       8'h82
`define RCS_UV_STATUS        8'h02
`define RCS_ZERO_BYTE        8'h00

// watchdog service sequence values
`define RCS_SVC_FIRST        8'h55
`define RCS_SVC_SECOND       8'hAA

// register select codes
`define RCS_SEL_STATUS       1'b0
`define RCS_SEL_DEBUG        1'b1

// force-reset bit inside the debug force-reset register
`define RCS_FORCE_BIT        0

// watchdog timeout select code that disables the watchdog
`define RCS_WDOG_OFF         2'b00

// cycles the system reset request stands after entry
`define RCS_HOLD_DEFAULT     8

`endif

// ### core/rcs_pkg.sv
// Purpose: types shared by the reset cause and forced reset block
// Assumes: constants come from rcs_consts.svh
// Notes:   one register access per cycle at most
`include "rcs_consts.svh"

package rcs_pkg;

  // one register access from the cpu or the background debug host
  typedef struct packed {
    logic       wr;
    logic       rd;
    logic       sel;
    logic       from_debug;
    logic [7:0] wdata;
  } rcs_bus_req_type;

  // reset-source events from logic on the bus clock
  typedef struct packed {
    logic illegal_opcode;
    logic stop_instruction;
    logic background_instruction;
    logic bad_address;
    logic osc_missing;
    logic watchdog_timeout;
  } rcs_sources_type;

  // option bits held elsewhere in the system
  typedef struct packed {
    logic [1:0] watchdog_timeout_select;
    logic       watchdog_window_mode;
    logic       watchdog_window_early;
    logic       stop_allow;
    logic       background_mode_allow;
    logic       undervoltage_reset_enable;
  } rcs_options_type;

  typedef enum logic {
    SVC_IDLE,
    SVC_ARMED
  } rcs_svc_type;

endpackage

// ### core/rcs_reset_cause.sv
// Purpose: records the cause of the last reset, decodes watchdog service
//          writes and debug forced resets, and requests system reset
// Assumes: reset_n is the power-on reset of this block; the watchdog counter
//          and the option registers live outside
// Notes:   reset_pin_n and low_voltage arrive from pins and are synchronised
`timescale 1ns/1ns
`include "rcs_consts.svh"

module rcs_reset_cause #(
  parameter int HOLD_CYCLES = `RCS_HOLD_DEFAULT
) (
  input  wire logic                     clk,
  input  wire logic                     reset_n,
  input  wire rcs_pkg::rcs_bus_req_type bus,
  input  wire rcs_pkg::rcs_sources_type sources,
  input  wire rcs_pkg::rcs_options_type options,
  input  wire logic                     reset_pin_n,
  input  wire logic                     low_voltage,
  output logic [7:0]                    rdata,
  output logic [7:0]                    status,
  output logic                          mcu_reset,
  output logic                          watchdog_clear
);
  import rcs_pkg::*;

  localparam int HW = $clog2(HOLD_CYCLES + 1);

  logic        pin_meta;
  logic        pin_sync;
  logic        uv_meta;
  logic        uv_sync;
  logic [HW-1:0] hold_count;
  rcs_svc_type svc_state;
  logic        wdog_enabled;
  logic        status_wr;
  logic        svc_value;
  logic        window_hit;
  logic        bad_write;
  logic        debug_force;
  logic        opcode_fault;
  logic        uv_trip;
  logic [7:0]  cause;
  logic        entry;
  logic        service_ok;

  // pins pass two flops before anything reads them
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      pin_meta <= 1'b1;
      pin_sync <= 1'b1;
    end else begin
      pin_meta <= reset_pin_n;
      pin_sync <= pin_meta;
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      uv_meta <= 1'b0;
      uv_sync <= 1'b0;
    end else begin
      uv_meta <= low_voltage;
      uv_sync <= uv_meta;
    end
  end

  // the cpu is held in reset while mcu_reset stands, so its writes are dropped
  assign wdog_enabled = options.watchdog_timeout_select != `RCS_WDOG_OFF;
  assign status_wr    = bus.wr && (bus.sel == `RCS_SEL_STATUS) && !mcu_reset;
  assign svc_value    = (bus.wdata == `RCS_SVC_FIRST) || (bus.wdata == `RCS_SVC_SECOND);
  assign window_hit   = options.watchdog_window_mode && options.watchdog_window_early;
  assign bad_write    = status_wr && wdog_enabled && (!svc_value || window_hit);

  // user program writes to the debug register carry no effect
  assign debug_force = bus.wr && (bus.sel == `RCS_SEL_DEBUG) && bus.from_debug
                       && bus.wdata[`RCS_FORCE_BIT] && !mcu_reset;

  assign opcode_fault = sources.illegal_opcode
                        || (sources.stop_instruction && !options.stop_allow)
                        || (sources.background_instruction && !options.background_mode_allow);

  assign uv_trip = options.undervoltage_reset_enable && uv_sync;

  always_comb begin
    cause = `RCS_ZERO_BYTE;
    cause[`RCS_BIT_EXT_LINE]    = !pin_sync;
    cause[`RCS_BIT_WATCHDOG]    = (sources.watchdog_timeout && wdog_enabled) || bad_write;
    cause[`RCS_BIT_BAD_OPCODE]  = opcode_fault;
    cause[`RCS_BIT_BAD_ADDRESS] = sources.bad_address;
    cause[`RCS_BIT_OSC_MISSING] = sources.osc_missing;
  end

  // a debug force with no other cause leaves the cause vector empty
  assign entry = !mcu_reset && (uv_trip || (cause != `RCS_ZERO_BYTE) || debug_force);

  // status is caught once at reset entry and then only read
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      status <= `RCS_POR_STATUS;
    end else if (entry) begin
      if (uv_trip) begin
        status <= `RCS_UV_STATUS;
      end else begin
        status <= cause;
      end
    end
  end

  // system reset request stands for HOLD_CYCLES cycles after entry
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      hold_count <= '0;
      mcu_reset  <= 1'b0;
    end else if (entry) begin
      hold_count <= HW'(HOLD_CYCLES - 1);
      mcu_reset  <= 1'b1;
    end else if (hold_count != '0) begin
      hold_count <= hold_count - HW'(1);
    end else begin
      mcu_reset <= 1'b0;
    end
  end

  // 0xAA only services when the last status write was 0x55
  assign service_ok = status_wr && !bad_write && (bus.wdata == `RCS_SVC_SECOND)
                      && (svc_state == SVC_ARMED);

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      svc_state <= SVC_IDLE;
    end else if (entry) begin
      svc_state <= SVC_IDLE;
    end else if (status_wr) begin
      if (bus.wdata == `RCS_SVC_FIRST) begin
        svc_state <= SVC_ARMED;
      end else begin
        svc_state <= SVC_IDLE;
      end
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      watchdog_clear <= 1'b0;
    end else begin
      watchdog_clear <= service_ok;
    end
  end

  // read data lands one cycle after the read strobe
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      rdata <= `RCS_ZERO_BYTE;
    end else if (bus.rd) begin
      if (bus.sel == `RCS_SEL_STATUS) begin
        rdata <= status;
      end else begin
        rdata <= `RCS_ZERO_BYTE;
      end
    end
  end

  // helper: set at the first reset entry after power-on
  logic por_seen;
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      por_seen <= 1'b0;
    end else if (entry) begin
      por_seen <= 1'b1;
    end
  end

  // helper: counts the cycles the reset request has stood, so the hold length
  // is checked without a long repetition
  logic [HW-1:0] high_count;
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      high_count <= '0;
    end else if (mcu_reset) begin
      high_count <= high_count + HW'(1);
    end else begin
      high_count <= '0;
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);

  chk_power_up_value: assert property (
    !por_seen |-> status == `RCS_POR_STATUS)
    else $error("power-on status is not power-up plus undervoltage");

  chk_flags_hold_steady: assert property (
    !entry |=> status == $past(status))
    else $error("status changed without a reset entry");

  chk_debug_leaves_clear: assert property (
    debug_force && !uv_trip && cause == `RCS_ZERO_BYTE |=> status == `RCS_ZERO_BYTE && mcu_reset)
    else $error("debug forced reset left a status flag set");

  chk_bad_value_resets: assert property (
    status_wr && wdog_enabled && !svc_value && !uv_trip |=> mcu_reset && status[`RCS_BIT_WATCHDOG])
    else $error("bad service value did not force a watchdog reset");

  chk_service_pair: assert property (
    status_wr && bus.wdata == `RCS_SVC_FIRST && !bad_write ##1
    status_wr && bus.wdata == `RCS_SVC_SECOND && !bad_write |=> watchdog_clear && $stable(status))
    else $error("0x55 then 0xAA did not clear the watchdog");

  chk_undervoltage_only: assert property (
    entry && uv_trip |=> status == `RCS_UV_STATUS)
    else $error("undervoltage reset recorded other flags");

  chk_sources_caught: assert property (
    entry && !uv_trip |=> status[`RCS_BIT_EXT_LINE] == !$past(pin_sync)
      && status[`RCS_BIT_BAD_ADDRESS] == $past(sources.bad_address)
      && status[`RCS_BIT_OSC_MISSING] == $past(sources.osc_missing)
      && status[`RCS_BIT_POWERUP] == 1'b0)
    else $error("reset entry did not record the active sources");

  chk_watchdog_blocked: assert property (
    entry && !uv_trip && options.watchdog_timeout_select == `RCS_WDOG_OFF
    |=> !status[`RCS_BIT_WATCHDOG])
    else $error("watchdog flag set while watchdog disabled");

  chk_stop_disallowed: assert property (
    entry && !uv_trip && sources.stop_instruction && !options.stop_allow
    |=> status[`RCS_BIT_BAD_OPCODE])
    else $error("disallowed stop did not set the bad opcode flag");

  chk_user_force_ignored: assert property (
    bus.wr && bus.sel == `RCS_SEL_DEBUG && !bus.from_debug && !mcu_reset && !uv_trip
      && cause == `RCS_ZERO_BYTE |=> !mcu_reset)
    else $error("user program write to the debug register forced a reset");

  chk_debug_reads_zero: assert property (
    bus.rd && bus.sel == `RCS_SEL_DEBUG |=> rdata == `RCS_ZERO_BYTE)
    else $error("debug force-reset register read nonzero");

  chk_force_holds_reset: assert property (
    debug_force |=> mcu_reset [*4])
    else $error("forced reset request did not stand");

  chk_window_early_write: assert property (
    status_wr && wdog_enabled && window_hit |=> mcu_reset && !watchdog_clear)
    else $error("early write in window mode did not reset");

  chk_lone_second_value: assert property (
    watchdog_clear |-> $past(svc_state) == SVC_ARMED
      && $past(bus.wdata) == `RCS_SVC_SECOND)
    else $error("watchdog cleared without a preceding 0x55");

  // read-back, sequencing and hold-length checks; these guard the paths that
  // the flag checks above leave open
  chk_read_tracks_status: assert property (
    bus.rd && bus.sel == `RCS_SEL_STATUS |=> rdata == $past(status))
    else $error("status read did not return the recorded flags");

  chk_rdata_holds: assert property (
    !bus.rd |=> $stable(rdata))
    else $error("read data changed without a read");

  chk_steady_in_reset: assert property (
    mcu_reset |=> status == $past(status))
    else $error("status changed while the reset request stood");

  chk_clear_single_pulse: assert property (
    watchdog_clear |=> !watchdog_clear)
    else $error("watchdog clear stood for more than one cycle");

  chk_first_value_arms: assert property (
    status_wr && !entry && bus.wdata == `RCS_SVC_FIRST |=> svc_state == SVC_ARMED)
    else $error("0x55 write did not arm the service sequence");

  chk_release_after_hold: assert property (
    $fell(mcu_reset) |-> high_count == HW'(HOLD_CYCLES))
    else $error("reset request did not stand for the hold length");

  chk_zero_bit_ignored: assert property (
    bus.wr && bus.sel == `RCS_SEL_DEBUG && !bus.wdata[`RCS_FORCE_BIT] && !mcu_reset && !uv_trip
      && cause == `RCS_ZERO_BYTE |=> !mcu_reset)
    else $error("debug write with the force bit clear forced a reset");

  chk_watchdog_flag_set: assert property (
    entry && !uv_trip && sources.watchdog_timeout && options.watchdog_timeout_select != `RCS_WDOG_OFF
    |=> status[`RCS_BIT_WATCHDOG])
    else $error("watchdog timeout did not set the watchdog flag");

  chk_opcode_flag_set: assert property (
    entry && !uv_trip
      && (sources.illegal_opcode || (sources.background_instruction && !options.background_mode_allow))
    |=> status[`RCS_BIT_BAD_OPCODE])
    else $error("illegal or disallowed instruction did not set the bad opcode flag");

  chk_allowed_stop_quiet: assert property (
    entry && !uv_trip && !sources.illegal_opcode && !sources.background_instruction && options.stop_allow
    |=> !status[`RCS_BIT_BAD_OPCODE])
    else $error("allowed stop set the bad opcode flag");

  chk_undervoltage_off_quiet: assert property (
    !options.undervoltage_reset_enable && !mcu_reset && !debug_force && cause == `RCS_ZERO_BYTE
    |=> !mcu_reset)
    else $error("undervoltage caused a reset while its reset was disabled");

  chk_lone_second_idle: assert property (
    status_wr && bus.wdata == `RCS_SVC_SECOND && svc_state == SVC_IDLE |=> !watchdog_clear)
    else $error("0xAA without a preceding 0x55 cleared the watchdog");

  chk_entry_disarms: assert property (
    entry |=> svc_state == SVC_IDLE)
    else $error("reset entry left the service sequence armed");

  chk_powerup_only_at_start: assert property (
    por_seen |-> !status[`RCS_BIT_POWERUP])
    else $error("power-up flag set after a later reset");

  cov_service_done: cover property (watchdog_clear);
  cov_lone_second:  cover property (status_wr && bus.wdata == `RCS_SVC_SECOND && svc_state == SVC_IDLE);
  cov_debug_force:  cover property (debug_force ##1 mcu_reset);
  cov_uv_reset:     cover property (entry && uv_trip);
  cov_window_reset: cover property (status_wr && window_hit && wdog_enabled);

endmodule

// ### testbench/rcs_host_model.sv
// Purpose: cpu program and serial debug host issuing register accesses
// Assumes: one access per cycle, strobes one cycle wide, driven 1 ns after the edge
// Notes:   write data is inverted once released so stale data is never trusted
`timescale 1ns/1ns
module rcs_host_model (
  input  wire logic                clk,
  output rcs_pkg::rcs_bus_req_type bus
);
  import rcs_pkg::*;

  initial bus = '{1'b0, 1'b0, 1'b0, 1'b0, 8'hA5};

  // w=1 write, w=0 read; d=1 marks a serial debug command
  task automatic access(input logic w, input logic s, input logic d, input logic [7:0] v);
    @(posedge clk);
    #1;
    bus = '{w, !w, s, d, v};
    @(posedge clk);
    #1;
    bus = '{1'b0, 1'b0, s, 1'b0, ~v};
  endtask

  // two user writes on back-to-back edges, the tightest spacing allowed
  task automatic write_pair(input logic s, input logic [7:0] v1, input logic [7:0] v2);
    @(posedge clk);
    #1;
    bus = '{1'b1, 1'b0, s, 1'b0, v1};
    @(posedge clk);
    #1;
    bus = '{1'b1, 1'b0, s, 1'b0, v2};
    @(posedge clk);
    #1;
    bus = '{1'b0, 1'b0, s, 1'b0, ~v2};
  endtask
endmodule

// ### testbench/tb.sv
// Purpose: self-checking bench for the reset cause and forced reset block
// Assumes: hold count shortened to 5, watchdog timeout select 01 by default
// Notes:   pin and undervoltage causes pass a two-flop sync, so entry is awaited
`timescale 1ns/1ns
module tb;
  import rcs_pkg::*;
  localparam rcs_options_type OPT_DEF = '{2'b01, 1'b0, 1'b0, 1'b1, 1'b1, 1'b1};
  localparam int              HOLD    = 5;
  logic            clk;
  logic            reset_n;
  logic            reset_pin_n;
  logic            low_voltage;
  logic            mcu_reset;
  logic            watchdog_clear;
  logic [7:0]      rdata;
  logic [7:0]      status;
  rcs_bus_req_type bus;
  rcs_sources_type sources;
  rcs_options_type options;
  logic [7:0]      exp_tab [6] = '{8'h20, 8'h04, 8'h08, 8'h10, 8'h10, 8'h10};
  int              n_mismatch = 0;
  int              n_compared = 0;

  rcs_host_model i_host (.clk(clk), .bus(bus));
  rcs_reset_cause #(.HOLD_CYCLES(HOLD)) i_dut (.clk(clk), .reset_n(reset_n), .bus(bus), .sources(sources),
    .options(options), .reset_pin_n(reset_pin_n), .low_voltage(low_voltage), .rdata(rdata),
    .status(status), .mcu_reset(mcu_reset), .watchdog_clear(watchdog_clear));

  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  task automatic chk(input string name, input logic [7:0] seen, input logic [7:0] exp);
    n_compared++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("mismatch %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask

  // waits for reset entry, drops all causes, checks flags and the hold length
  task automatic expect_reset(input logic [7:0] exp);
    int k;
    k = 0;
    while (mcu_reset !== 1'b1 && k < 8) begin
      tick(1);
      k++;
    end
    sources = '0;
    options = OPT_DEF;
    reset_pin_n = 1'b1;
    low_voltage = 1'b0;
    chk("mcu_reset", {7'h00, mcu_reset}, 8'h01);
    chk("status", status, exp);
    k = 0;
    while (mcu_reset !== 1'b0 && k < 12) begin
      tick(1);
      k++;
    end
    chk("hold", k[7:0], 8'(HOLD));
    tick(2);
  endtask

  task automatic end_of_test;
    $display("compared %0d mismatches %0d", n_compared, n_mismatch);
    if (n_mismatch == 0 && n_compared > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  initial begin
    #(20 * 3000);
    n_mismatch++;
    end_of_test();
  end

  initial begin
    reset_n = 1'b0;
    reset_pin_n = 1'b1;
    low_voltage = 1'b0;
    sources = '0;
    options = OPT_DEF;
    tick(20);
    reset_n = 1'b1;
    tick(1);
    chk("por status", status, 8'h82);
    i_host.access(1'b0, 1'b0, 1'b0, 8'h00);
    tick(1);
    chk("rdata status", rdata, 8'h82);
    i_host.access(1'b1, 1'b0, 1'b0, 8'hAA);
    chk("lone second", {7'h00, watchdog_clear}, 8'h00);
    i_host.access(1'b1, 1'b0, 1'b0, 8'h55);
    i_host.access(1'b1, 1'b0, 1'b0, 8'hAA);
    chk("service", {7'h00, watchdog_clear}, 8'h01);
    chk("kept status", status, 8'h82);
    i_host.write_pair(1'b0, 8'h55, 8'hAA);
    chk("service pair", {7'h00, watchdog_clear}, 8'h01);
    i_host.write_pair(1'b0, 8'h55, 8'h55);
    i_host.access(1'b1, 1'b0, 1'b0, 8'hAA);
    chk("double first", {7'h00, watchdog_clear}, 8'h01);
    i_host.access(1'b1, 1'b1, 1'b0, 8'h01);
    tick(1);
    chk("user force", {7'h00, mcu_reset}, 8'h00);
    i_host.access(1'b0, 1'b1, 1'b1, 8'hFF);
    tick(1);
    chk("debug read", rdata, 8'h00);
    i_host.access(1'b1, 1'b1, 1'b1, 8'h01);
    expect_reset(8'h00);
    i_host.access(1'b1, 1'b0, 1'b0, 8'h12);
    expect_reset(8'h20);
    options.watchdog_window_mode = 1'b1;
    options.watchdog_window_early = 1'b1;
    i_host.access(1'b1, 1'b0, 1'b0, 8'h55);
    expect_reset(8'h20);
    for (int i = 0; i < 6; i++) begin
      sources = rcs_sources_type'(6'h01 << i);
      options.stop_allow = 1'b0;
      options.background_mode_allow = 1'b0;
      expect_reset(exp_tab[i]);
    end
    sources = '{1'b1, 1'b0, 1'b0, 1'b1, 1'b0, 1'b0};
    expect_reset(8'h18);
    reset_pin_n = 1'b0;
    expect_reset(8'h40);
    low_voltage = 1'b1;
    expect_reset(8'h02);
    // disabled watchdog, allowed stop and disabled undervoltage reset must stay quiet
    options.watchdog_timeout_select = 2'b00;
    options.undervoltage_reset_enable = 1'b0;
    sources = '{1'b0, 1'b1, 1'b0, 1'b0, 1'b0, 1'b1};
    low_voltage = 1'b1;
    tick(6);
    chk("no entry", {7'h00, mcu_reset}, 8'h00);
    end_of_test();
  end
endmodule
